// ==== rtl/fp_timing_pkg.sv ====
// Shared timing constants, types and operand-time helpers for the processor and float coprocessor ends.
package fp_timing_pkg;

  // Clock period.
  localparam int CLK_NS = 100;

  // Memory technology on the shared bus and operand precision.
  typedef enum logic {MEM_BIPOLAR, MEM_CORE16K} mem_kind_t;
  typedef enum logic [1:0] {OPK_INT, OPK_LONG, OPK_FLOAT, OPK_DOUBLE} op_kind_t;

  // Least times round up to whole cycles.
  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  // Longest times round down, never below one cycle.
  function automatic int cyc_dn(input int ns);
    return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
  endfunction

  // Handoff of an instruction to the coprocessor.
  localparam int HANDOFF_NS = 600;
  localparam int COP_JOIN_NS = 150;
  localparam int COP_PRIOR_NS = 450;
  localparam int HANDOFF_CYC = cyc_up(HANDOFF_NS);
  localparam int JOIN_CYC = cyc_up(COP_JOIN_NS);

  // Operand address calculation per mode.
  localparam int CALC_BIP_NS [8] = '{1120, 1260, 1260, 1650, 1260, 1800, 1650, 2080};
  localparam int CALC_CORE_NS [8] = '{1120, 1260, 1260, 2200, 1260, 2370, 2200, 3350};

  // One memory access per operand word, and the memory management surcharge.
  localparam int ACCESS_BIP_NS = 990;
  localparam int ACCESS_CORE_NS = 1820;
  localparam int MM_ACCESS_NS = 90;

  // Processor disengage from the coprocessor.
  localparam int DISENG_BIP_NS = 450;
  localparam int DISENG_CORE_NS = 1140;

  // Interrupt timing bounds.
  localparam int ACK_MAX_BIP_NS = 9000;
  localparam int ACK_MAX_CORE_NS = 12620;
  localparam int SVC_BIP_NS = 2250;
  localparam int SVC_CORE_NS = 5440;
  localparam int TOTAL_WORST_BIP_NS = 11250;
  localparam int TOTAL_WORST_MM_NS = 11700;
  localparam int TOTAL_AVG_BIP_NS = 3950;
  localparam int TOTAL_AVG_MM_NS = 4400;
  localparam int INSTR_MAX_BIP_CYC = cyc_dn(ACK_MAX_BIP_NS);
  localparam int INSTR_MAX_CORE_CYC = cyc_dn(ACK_MAX_CORE_NS);
  localparam int SVC_BIP_CYC = cyc_dn(SVC_BIP_NS);
  localparam int SVC_CORE_CYC = cyc_dn(SVC_CORE_NS);

  // Words fetched per operand precision.
  function automatic int op_words(input op_kind_t k);
    case (k)
      OPK_INT: return 1;
      OPK_DOUBLE: return 4;
      default: return 2;
    endcase
  endfunction

  // One memory access in cycles.
  function automatic int access_cycles(input mem_kind_t m, input logic mm);
    return cyc_up((m == MEM_BIPOLAR ? ACCESS_BIP_NS : ACCESS_CORE_NS) + (mm ? MM_ACCESS_NS : 0));
  endfunction

  // Operand time: calculation plus one access per word, none in mode 0.
  function automatic int operand_cycles(input mem_kind_t m, input logic [2:0] mode, input op_kind_t k,
                                        input logic mm);
    int calc;
    int acc;
    calc = (m == MEM_BIPOLAR) ? CALC_BIP_NS[mode] : CALC_CORE_NS[mode];
    acc = (m == MEM_BIPOLAR ? ACCESS_BIP_NS : ACCESS_CORE_NS) + (mm ? MM_ACCESS_NS : 0);
    return cyc_up(calc + ((mode == 3'h0) ? 0 : op_words(k) * acc));
  endfunction

endpackage

// ==== rtl/float_coprocessor_if.sv ====
// Link between the processor and the float coprocessor.
`timescale 1ns/1ps
`default_nettype none
interface float_coprocessor_if;
  import fp_timing_pkg::*;
  logic hand_active;
  logic hand_join;
  logic [2:0] hand_mode;
  op_kind_t hand_kind;
  logic [7:0] hand_exec;
  mem_kind_t hand_mem;
  logic hand_mm;
  logic cop_ready;

  modport cpu_side (output hand_active, hand_join, hand_mode, hand_kind, hand_exec, hand_mem, hand_mm,
                    input cop_ready);
  modport cop_side (input hand_active, hand_join, hand_mode, hand_kind, hand_exec, hand_mem, hand_mm,
                    output cop_ready);
endinterface
`default_nettype wire

// ==== rtl/phase_timer.sv ====
// Down-counter that times one phase of a sequence.
`timescale 1ns/1ps
`default_nettype none
module phase_timer import fp_timing_pkg::*; #(
  parameter int W = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Load and status
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  if (W < 2) begin : g_bad_width
    $error("phase_timer needs W of at least 2");
  end

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != '0) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;
  assign done = (count_reg == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ==== rtl/cpu_end.sv ====
// Processor end: instruction sequencing, coprocessor handoff and interrupt acknowledge.
`timescale 1ns/1ps
`default_nettype none
module cpu_end import fp_timing_pkg::*; #(
  parameter int CW = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic instr_float,
  input wire logic [2:0] instr_src_mode,
  input wire op_kind_t instr_op_kind,
  input wire logic [7:0] instr_exec_cyc,
  input wire logic [7:0] ord_cyc,
  output logic instr_taken,
  output logic cpu_busy,
  // System configuration
  input wire mem_kind_t mem_kind,
  input wire logic mm_on,
  // Interrupt request pin and acknowledge
  input wire logic bus_interrupt_request,
  output logic irq_ack,
  output logic svc_fetch,
  // Coprocessor link
  float_coprocessor_if.cpu_side link
);
  typedef enum {ST_IDLE, ST_ORD, ST_WAITCOP, ST_HAND, ST_OPER, ST_DISENG, ST_FETCH, ST_SVC} cpu_state_t;

  if (CW < 8) begin : g_bad_width
    $error("cpu_end needs CW of at least 8");
  end

  cpu_state_t state_reg;
  cpu_state_t state_next;
  logic irq_s1_reg;
  logic irq_s2_reg;
  logic taken_reg;
  logic taken_next;
  logic ack_reg;
  logic ack_next;
  logic svc_reg;
  logic svc_next;
  logic busy_reg;
  logic busy_next;
  logic act_reg;
  logic act_next;
  logic join_reg;
  logic join_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  op_kind_t kind_reg;
  op_kind_t kind_next;
  logic [7:0] exec_reg;
  logic [7:0] exec_next;
  mem_kind_t mem_reg;
  mem_kind_t mem_next;
  logic mm_reg;
  logic mm_next;
  logic t_load;
  logic [CW-1:0] t_val;
  logic [CW-1:0] t_count;
  logic t_done;
  logic [CW-1:0] instr_cap;

  phase_timer #(.W(CW)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .load(t_load),
    .load_val(t_val),
    .count(t_count),
    .done(t_done)
  );

  // Request pin passes two flip-flops.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
    end else if (ce) begin
      irq_s1_reg <= bus_interrupt_request;
      irq_s2_reg <= irq_s1_reg;
    end
  end

  // Execute part is capped so that, with its fetch, it fits within the slowest instruction.
  assign instr_cap = (mem_kind == MEM_BIPOLAR) ? CW'(INSTR_MAX_BIP_CYC - access_cycles(mem_kind, mm_on)) :
                                                 CW'(INSTR_MAX_CORE_CYC - access_cycles(mem_kind, mm_on));

  always_comb begin
    state_next = state_reg;
    taken_next = 1'b0;
    ack_next = 1'b0;
    svc_next = 1'b0;
    mode_next = mode_reg;
    kind_next = kind_reg;
    exec_next = exec_reg;
    mem_next = mem_reg;
    mm_next = mm_reg;
    t_load = 1'b0;
    t_val = '0;
    case (state_reg)
      ST_IDLE: begin
        if (instr_valid) begin
          taken_next = 1'b1;
          mode_next = instr_src_mode;
          kind_next = instr_op_kind;
          exec_next = instr_exec_cyc;
          mem_next = mem_kind;
          mm_next = mm_on;
          if (instr_float) begin
            if (link.cop_ready) begin
              state_next = ST_HAND;
              t_load = 1'b1;
              t_val = CW'(HANDOFF_CYC);
            end else begin
              state_next = ST_WAITCOP;
            end
          end else begin
            state_next = ST_ORD;
            t_load = 1'b1;
            if (ord_cyc == 8'h00) begin
              t_val = CW'(1);
            end else if (CW'(ord_cyc) > instr_cap) begin
              t_val = instr_cap;
            end else begin
              t_val = CW'(ord_cyc);
            end
          end
        end
      end
      ST_ORD: begin
        if (t_done) begin
          state_next = ST_FETCH;
          t_load = 1'b1;
          t_val = CW'(access_cycles(mem_reg, mm_reg));
        end
      end
      ST_WAITCOP: begin
        if (link.cop_ready) begin
          state_next = ST_HAND;
          t_load = 1'b1;
          t_val = CW'(HANDOFF_CYC);
        end
      end
      ST_HAND: begin
        if (t_done) begin
          state_next = ST_OPER;
          t_load = 1'b1;
          t_val = CW'(operand_cycles(mem_reg, mode_reg, kind_reg, mm_reg));
        end
      end
      ST_OPER: begin
        if (t_done) begin
          state_next = ST_DISENG;
          t_load = 1'b1;
          t_val = (mem_reg == MEM_BIPOLAR) ? CW'(cyc_up(DISENG_BIP_NS)) : CW'(cyc_up(DISENG_CORE_NS));
        end
      end
      ST_DISENG: begin
        if (t_done) begin
          state_next = ST_FETCH;
          t_load = 1'b1;
          t_val = CW'(access_cycles(mem_reg, mm_reg));
        end
      end
      ST_FETCH: begin
        if (t_done) begin
          if (irq_s2_reg) begin
            ack_next = 1'b1;
            state_next = ST_SVC;
            t_load = 1'b1;
            t_val = (mem_reg == MEM_BIPOLAR) ? CW'(SVC_BIP_CYC) : CW'(SVC_CORE_CYC);
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_SVC: begin
        if (t_done) begin
          svc_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
    act_next = (state_next == ST_HAND);
    join_next = (state_reg == ST_HAND) && !t_done && (t_count - 1'b1 <= CW'(JOIN_CYC));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      taken_reg <= 1'b0;
      ack_reg <= 1'b0;
      svc_reg <= 1'b0;
      busy_reg <= 1'b0;
      act_reg <= 1'b0;
      join_reg <= 1'b0;
      mode_reg <= 3'h0;
      kind_reg <= OPK_INT;
      exec_reg <= 8'h00;
      mem_reg <= MEM_BIPOLAR;
      mm_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      taken_reg <= taken_next;
      ack_reg <= ack_next;
      svc_reg <= svc_next;
      busy_reg <= busy_next;
      act_reg <= act_next;
      join_reg <= join_next;
      mode_reg <= mode_next;
      kind_reg <= kind_next;
      exec_reg <= exec_next;
      mem_reg <= mem_next;
      mm_reg <= mm_next;
    end
  end

  assign instr_taken = taken_reg;
  assign cpu_busy = busy_reg;
  assign irq_ack = ack_reg;
  assign svc_fetch = svc_reg;
  assign link.hand_active = act_reg;
  assign link.hand_join = join_reg;
  assign link.hand_mode = mode_reg;
  assign link.hand_kind = kind_reg;
  assign link.hand_exec = exec_reg;
  assign link.hand_mem = mem_reg;
  assign link.hand_mm = mm_reg;
endmodule
`default_nettype wire

// ==== rtl/fpp_end.sv ====
// Float coprocessor end: joins the handoff, fetches operands and executes.
`timescale 1ns/1ps
`default_nettype none
module fpp_end import fp_timing_pkg::*; #(
  parameter int CW = 8
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Status
  output logic fpp_busy,
  output logic exec_done,
  // Processor link
  float_coprocessor_if.cop_side link
);
  typedef enum {FS_IDLE, FS_JOIN, FS_OPER, FS_EXEC} fpp_state_t;

  if (CW < 8) begin : g_bad_width
    $error("fpp_end needs CW of at least 8");
  end

  fpp_state_t state_reg;
  fpp_state_t state_next;
  logic ready_reg;
  logic ready_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  logic [7:0] exec_reg;
  logic [7:0] exec_next;
  logic t_load;
  logic [CW-1:0] t_val;
  logic t_done;

  phase_timer #(.W(CW)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .load(t_load),
    .load_val(t_val),
    .count(),
    .done(t_done)
  );

  always_comb begin
    state_next = state_reg;
    done_next = 1'b0;
    exec_next = exec_reg;
    t_load = 1'b0;
    t_val = '0;
    case (state_reg)
      FS_IDLE: begin
        if (link.hand_join) begin
          state_next = FS_JOIN;
          exec_next = (link.hand_exec == 8'h00) ? 8'h01 : link.hand_exec;
        end
      end
      FS_JOIN: begin
        if (!link.hand_join) begin
          state_next = FS_OPER;
          t_load = 1'b1;
          t_val = CW'(operand_cycles(link.hand_mem, link.hand_mode, link.hand_kind, link.hand_mm));
        end
      end
      FS_OPER: begin
        if (t_done) begin
          state_next = FS_EXEC;
          t_load = 1'b1;
          t_val = CW'(exec_reg);
        end
      end
      FS_EXEC: begin
        if (t_done) begin
          state_next = FS_IDLE;
          done_next = 1'b1;
        end
      end
      default: begin
        state_next = FS_IDLE;
      end
    endcase
    ready_next = (state_next == FS_IDLE);
    busy_next = (state_next != FS_IDLE);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= FS_IDLE;
      ready_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      exec_reg <= 8'h01;
    end else if (ce) begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      exec_reg <= exec_next;
    end
  end

  assign link.cop_ready = ready_reg;
  assign fpp_busy = busy_reg;
  assign exec_done = done_reg;
endmodule
`default_nettype wire

// ==== tb/fp_link_monitor.sv ====
// Concurrent checks on the processor to coprocessor link.
`timescale 1ns/1ps
`default_nettype none
module fp_link_monitor import fp_timing_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic hand_active,
  input wire logic hand_join,
  input wire logic [2:0] hand_mode,
  input wire op_kind_t hand_kind,
  input wire logic [7:0] hand_exec,
  input wire mem_kind_t hand_mem,
  input wire logic hand_mm,
  input wire logic cop_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start;
    $rose(hand_active);
  endsequence
  sequence s_join_late;
    !hand_join[*4] ##1 hand_join[*2] ##1 !hand_join;
  endsequence
  AST_HAND_LEN: assert property (s_start |-> hand_active[*6] ##1 !hand_active)
    else $error("handoff length wrong");
  AST_JOIN_LATE: assert property (s_start |-> s_join_late)
    else $error("coprocessor joined handoff at the wrong time");
  AST_JOIN_INSIDE: assert property (hand_join |-> hand_active)
    else $error("join outside handoff");
  AST_READY_START: assert property (s_start |-> $past(cop_ready))
    else $error("handoff started while coprocessor busy");
  AST_READY_FALL: assert property ($fell(hand_join) |-> !cop_ready)
    else $error("coprocessor still ready after joining");
  AST_READY_LOW: assert property ($fell(cop_ready) |-> !cop_ready[*8])
    else $error("coprocessor finished faster than its operand phase");
  AST_EXEC_BOUND: assert property ($fell(cop_ready) |-> ##[1:400] cop_ready)
    else $error("coprocessor never became ready again");
  AST_HAND_GAP: assert property ($fell(hand_active) |-> !hand_active[*8])
    else $error("new handoff before processor finished its phases");
  AST_FIELDS_STABLE: assert property (hand_active && !$rose(hand_active) |->
    $stable({hand_mode, hand_kind, hand_exec, hand_mem, hand_mm}))
    else $error("handoff fields changed during handoff");
endmodule
`default_nettype wire

// ==== tb/test_cpu_fpp_instruction_timing.sv ====
// Self-checking bench for the processor and float coprocessor ends.
`timescale 1ns/1ps
`default_nettype none
module test_cpu_fpp_instruction_timing import fp_timing_pkg::*; ;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic instr_float = 1'b0;
  logic [2:0] instr_src_mode = 3'h0;
  op_kind_t instr_op_kind = OPK_INT;
  logic [7:0] instr_exec_cyc = 8'h01;
  logic [7:0] ord_cyc = 8'h01;
  mem_kind_t mem_kind = MEM_BIPOLAR;
  logic mm_on = 1'b0;
  logic bus_interrupt_request = 1'b0;
  logic instr_taken;
  logic cpu_busy;
  logic irq_ack;
  logic svc_fetch;
  logic fpp_busy;
  logic exec_done;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int take_c;
  int idle_c;
  int done_c;
  int ack_c;
  int svc_c;
  int wd [4] = '{1, 2, 2, 4};
  float_coprocessor_if link_if ();
  cpu_end #(.CW(8)) i_cpu_end (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .instr_valid(instr_valid),
    .instr_float(instr_float), .instr_src_mode(instr_src_mode), .instr_op_kind(instr_op_kind),
    .instr_exec_cyc(instr_exec_cyc), .ord_cyc(ord_cyc), .instr_taken(instr_taken), .cpu_busy(cpu_busy),
    .mem_kind(mem_kind), .mm_on(mm_on), .bus_interrupt_request(bus_interrupt_request), .irq_ack(irq_ack),
    .svc_fetch(svc_fetch), .link(link_if));
  fpp_end #(.CW(8)) i_fpp_end (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .fpp_busy(fpp_busy),
    .exec_done(exec_done), .link(link_if));
  fp_link_monitor i_fp_link_monitor (.clk(clk), .sys_rst(sys_rst), .hand_active(link_if.hand_active),
    .hand_join(link_if.hand_join), .hand_mode(link_if.hand_mode), .hand_kind(link_if.hand_kind),
    .hand_exec(link_if.hand_exec), .hand_mem(link_if.hand_mem), .hand_mm(link_if.hand_mm),
    .cop_ready(link_if.cop_ready));
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(negedge clk) begin
    if (exec_done === 1'b1) done_c = cyc;
    if (irq_ack === 1'b1) ack_c = cyc;
    if (svc_fetch === 1'b1) svc_c = cyc;
  end
  function automatic int ceil_c(input int ns);
    return (ns + 99) / 100;
  endfunction
  function automatic int acc_ns();
    return (mem_kind == MEM_BIPOLAR ? ACCESS_BIP_NS : ACCESS_CORE_NS) + (mm_on ? MM_ACCESS_NS : 0);
  endfunction
  function automatic int op_c(input int md, input int w);
    return ceil_c((mem_kind == MEM_BIPOLAR ? CALC_BIP_NS[md] : CALC_CORE_NS[md]) + (md == 0 ? 0 : w * acc_ns()));
  endfunction
  task automatic check_rng(input string what, input int lo, input int hi, input int seen);
    checks_done++;
    if (seen < lo || seen > hi) begin
      num_errors++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask
  task automatic check_bit(input string what, input logic exp, input logic seen);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic issue(input logic fl, input logic [2:0] md, input op_kind_t k, input logic [7:0] ex,
                       input logic [7:0] oc);
    int n;
    n = 0;
    @(negedge clk);
    instr_valid = 1'b1;
    instr_float = fl;
    instr_src_mode = md;
    instr_op_kind = k;
    instr_exec_cyc = ex;
    ord_cyc = oc;
    do begin
      @(negedge clk);
      n++;
    end while (instr_taken !== 1'b1 && n < 2000);
    instr_valid = 1'b0;
    take_c = cyc;
    check_rng("take wait", 1, 1999, n);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((cpu_busy !== 1'b0 || link_if.hand_active !== 1'b0) && n < 2000) begin
      @(negedge clk);
      n++;
    end
    idle_c = cyc;
  endtask
  task automatic wait_hand();
    int n;
    n = 0;
    while (link_if.hand_active !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    take_c = cyc;
  endtask
  task automatic wait_fpp(input int exp);
    int n;
    n = 0;
    while (link_if.cop_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    check_rng("fpp length", exp - 2, exp + 2, done_c - take_c);
  endtask
  task automatic run_ord(input logic [7:0] oc, input int e);
    issue(1'b0, 3'h0, OPK_INT, 8'h01, oc);
    wait_idle();
    check_rng("ordinary length", e + ceil_c(acc_ns()) - 2, e + ceil_c(acc_ns()) + 2, idle_c - take_c);
  endtask
  task automatic run_float(input int md, input op_kind_t k, input logic [7:0] ex, input logic wf);
    int e;
    e = 6 + op_c(md, wd[k]) + ceil_c(mem_kind == MEM_BIPOLAR ? DISENG_BIP_NS : DISENG_CORE_NS) + ceil_c(acc_ns());
    issue(1'b1, md[2:0], k, ex, 8'h01);
    wait_idle();
    check_rng("cpu float length", e - 2, e + 2, idle_c - take_c);
    if (wf) wait_fpp(7 + op_c(md, wd[k]) + ex);
  endtask
  task automatic run_irq(input logic [7:0] oc, input int svc, input int lim);
    int n;
    n = 0;
    issue(1'b0, 3'h0, OPK_INT, 8'h01, oc);
    bus_interrupt_request = 1'b1;
    while (svc_fetch !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
      if (irq_ack === 1'b1) bus_interrupt_request = 1'b0;
    end
    bus_interrupt_request = 1'b0;
    @(negedge clk);
    wait_idle();
    check_rng("ack at end", oc + ceil_c(acc_ns()) - 2, oc + ceil_c(acc_ns()) + 2, ack_c - take_c);
    check_rng("service time", svc - 1, svc, svc_c - ack_c);
    check_rng("request to service", 1, lim, svc_c - take_c + 1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    check_bit("ready after reset", 1'b1, link_if.cop_ready);
    check_bit("busy after reset", 1'b0, cpu_busy);
    run_ord(8'h03, 3);
    run_ord(8'hC8, INSTR_MAX_BIP_CYC - ceil_c(ACCESS_BIP_NS));
    for (int m = 0; m < 2; m++) begin
      mem_kind = mem_kind_t'(m);
      for (int md = 0; md < 8; md++) begin
        run_float(md, op_kind_t'(md % 4), 8'h05, 1'b1);
      end
    end
    run_ord(8'hC8, INSTR_MAX_CORE_CYC - ceil_c(ACCESS_CORE_NS));
    run_irq(8'h46, SVC_CORE_CYC, 200);
    mm_on = 1'b1;
    run_float(7, OPK_DOUBLE, 8'h05, 1'b1);
    mem_kind = MEM_BIPOLAR;
    run_irq(8'h46, SVC_BIP_CYC, TOTAL_WORST_MM_NS / CLK_NS);
    mm_on = 1'b0;
    run_irq(8'h46, SVC_BIP_CYC, TOTAL_WORST_BIP_NS / CLK_NS);
    run_irq(8'h06, SVC_BIP_CYC, TOTAL_AVG_BIP_NS / CLK_NS);
    run_float(1, OPK_FLOAT, 8'hC8, 1'b0);
    check_bit("coprocessor still busy", 1'b0, link_if.cop_ready);
    check_bit("coprocessor busy flag", 1'b1, fpp_busy);
    issue(1'b1, 3'h0, OPK_INT, 8'h05, 8'h01);
    wait_hand();
    check_rng("handoff after ready", 0, 3, take_c - done_c);
    wait_idle();
    wait_fpp(7 + op_c(0, 1) + 5);
    finish_test();
  end
endmodule
`default_nettype wire
